// ---- rtl/accel_pin_power_reset_regs.sv ----
// Accelerometer interrupt pin, event routing, self-test, power and soft-reset registers
//
// Notes on behaviour
// - Pin A config holds input enable 4, output enable 3, open-drain 2, active-high 1.
// - Pin B config uses the same field layout as pin A.
// - Routing bit 6 puts data-ready onto pin B.
// - Routing bit 5 puts FIFO watermark onto pin B.
// - Routing bit 4 puts FIFO full onto pin B.
// - Routing bit 2 puts data-ready onto pin A.
// - Routing bit 1 puts FIFO watermark onto pin A.
// - Routing bit 0 puts FIFO full onto pin A.
// - Stimulus 0x00 off, 0x0D positive offset, 0x09 negative offset.
// - Power-save 0x03 suspends, 0x00 activates; resets to 0x03.
// - While suspended no new samples are acquired.
// - Sensor enable 0x00 off, 0x04 on; resets to 0x00.
// - Writing 0xB6 to soft-reset register starts a sensor reset.
// - 1 ms after soft reset all configuration returns to reset values.
// - Soft reset is accepted in every mode, suspend included.
// - Watermark event holds while FIFO bytes reach the 13-bit threshold.
`timescale 1ns/1ps
module accel_pin_power_reset_regs #(
  parameter int SRST_CYCLES = accel_regs_pkg::SRST_DELAY_CYCLES
) (
  // Clock and reset
  input  wire logic                          CLK,
  input  wire logic                          RST_N,
  // Register port
  input  wire accel_regs_pkg::reg_req_s      REG_REQ,
  output logic [7:0]                         REG_RDATA,
  // Data path events and FIFO state
  input  wire accel_regs_pkg::events_s       EVENTS,
  input  wire logic [accel_regs_pkg::LEVEL_W-1:0] FIFO_LEVEL,
  input  wire logic [accel_regs_pkg::WTM_W-1:0]   WTM_LEVEL,
  // Interrupt pin A
  input  wire logic                          IRQ_PIN_A_I,
  output logic                               IRQ_PIN_A_O,
  output logic                               IRQ_PIN_A_OE,
  output logic                               PIN_A_SEEN,
  // Interrupt pin B
  input  wire logic                          IRQ_PIN_B_I,
  output logic                               IRQ_PIN_B_O,
  output logic                               IRQ_PIN_B_OE,
  output logic                               PIN_B_SEEN,
  // Sensor control
  output accel_regs_pkg::stim_e              STIMULUS,
  output logic                               ACQUIRE_EN,
  output logic                               SOFT_RESET_BUSY
);
  import accel_regs_pkg::*;

  pin_cfg_s   pin_a_r;
  pin_cfg_s   pin_b_r;
  logic [6:0] routing_r;
  logic [7:0] stimulus_r;
  logic [7:0] power_save_r;
  logic [7:0] sensor_on_r;
  logic       srst_busy_r;
  logic [15:0] srst_cnt_r;
  logic       srst_done;
  logic       wr_a;
  logic       wr_b;
  logic       wr_route;
  logic       wr_stim;
  logic       wr_pwr;
  logic       wr_on;
  logic       key_wr;
  logic       wm_evt;
  logic       evt_a;
  logic       evt_b;
  logic [1:0] sync_a_r;
  logic [1:0] sync_b_r;

  // Write decode
  assign wr_a     = REG_REQ.wr && REG_REQ.addr == OFS_PIN_A_CFG;
  assign wr_b     = REG_REQ.wr && REG_REQ.addr == OFS_PIN_B_CFG;
  assign wr_route = REG_REQ.wr && REG_REQ.addr == OFS_ROUTING;
  assign wr_stim  = REG_REQ.wr && REG_REQ.addr == OFS_STIMULUS;
  assign wr_pwr   = REG_REQ.wr && REG_REQ.addr == OFS_POWER_SAVE;
  assign wr_on    = REG_REQ.wr && REG_REQ.addr == OFS_SENSOR_ON;
  // Key write is taken in any power mode
  assign key_wr   = REG_REQ.wr && REG_REQ.addr == OFS_SOFT_RESET && REG_REQ.wdata == RESET_KEY;
  assign srst_done = srst_busy_r && srst_cnt_r == 16'(SRST_CYCLES - 1);

  // Soft reset delay counter; a repeated key restarts the delay
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      srst_busy_r <= 1'b0;
      srst_cnt_r  <= 16'h0000;
    end
    else if (key_wr)
    begin
      srst_busy_r <= 1'b1;
      srst_cnt_r  <= 16'h0000;
    end
    else if (srst_done)
    begin
      srst_busy_r <= 1'b0;
      srst_cnt_r  <= 16'h0000;
    end
    else if (srst_busy_r)
    begin
      srst_cnt_r <= srst_cnt_r + 16'h0001;
    end
  end

  // Pin configuration registers, reserved bits never stored
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pin_a_r <= pin_cfg_s'(PIN_CFG_RST[4:1]);
      pin_b_r <= pin_cfg_s'(PIN_CFG_RST[4:1]);
    end
    else if (srst_done)
    begin
      pin_a_r <= pin_cfg_s'(PIN_CFG_RST[4:1]);
      pin_b_r <= pin_cfg_s'(PIN_CFG_RST[4:1]);
    end
    else
    begin
      if (wr_a)
        pin_a_r <= pin_cfg_s'(REG_REQ.wdata[PIN_IN_EN_BIT:PIN_POL_BIT]);
      if (wr_b)
        pin_b_r <= pin_cfg_s'(REG_REQ.wdata[PIN_IN_EN_BIT:PIN_POL_BIT]);
    end
  end

  // Event routing register, bit 3 and bit 7 reserved
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      routing_r <= ROUTING_RST[6:0];
    else if (srst_done)
      routing_r <= ROUTING_RST[6:0];
    else if (wr_route)
      routing_r <= {REG_REQ.wdata[6:4], 1'b0, REG_REQ.wdata[2:0]};
  end

  // Self-test, power-save and sensor enable registers
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      stimulus_r   <= STIMULUS_RST;
      power_save_r <= POWER_SAVE_RST;
      sensor_on_r  <= SENSOR_ON_RST;
    end
    else if (srst_done)
    begin
      stimulus_r   <= STIMULUS_RST;
      power_save_r <= POWER_SAVE_RST;
      sensor_on_r  <= SENSOR_ON_RST;
    end
    else
    begin
      if (wr_stim)
        stimulus_r <= REG_REQ.wdata;
      if (wr_pwr)
        power_save_r <= REG_REQ.wdata;
      if (wr_on)
        sensor_on_r <= REG_REQ.wdata;
    end
  end

  // Stimulus decode; unlisted codes leave the output unstimulated
  always_comb
  begin
    unique case (stimulus_r)
      STIM_POS_VAL: STIMULUS = STIM_POS;
      STIM_NEG_VAL: STIMULUS = STIM_NEG;
      default:      STIMULUS = STIM_OFF;
    endcase
  end

  // Sampling runs only when active, switched on and not mid-reset
  assign ACQUIRE_EN = power_save_r == ACTIVE_VAL && sensor_on_r == SENSOR_ON_VAL && !srst_busy_r;
  assign SOFT_RESET_BUSY = srst_busy_r;

  // Read data, write-only and unmapped offsets read zero
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      REG_RDATA <= 8'h00;
    else if (REG_REQ.rd)
    begin
      unique case (REG_REQ.addr)
        OFS_PIN_A_CFG:  REG_RDATA <= {3'b000, pin_a_r, 1'b0};
        OFS_PIN_B_CFG:  REG_RDATA <= {3'b000, pin_b_r, 1'b0};
        OFS_ROUTING:    REG_RDATA <= {1'b0, routing_r};
        OFS_STIMULUS:   REG_RDATA <= stimulus_r;
        OFS_POWER_SAVE: REG_RDATA <= power_save_r;
        OFS_SENSOR_ON:  REG_RDATA <= sensor_on_r;
        default:        REG_RDATA <= 8'h00;
      endcase
    end
  end

  // Watermark event from fill level against threshold
  assign wm_evt = FIFO_LEVEL >= LEVEL_W'(WTM_LEVEL);

  // Event merge per pin
  assign evt_a = (routing_r[ROUTE_READY_A_BIT] && EVENTS.data_ready)
              || (routing_r[ROUTE_LEVEL_A_BIT] && wm_evt)
              || (routing_r[ROUTE_FULL_A_BIT] && EVENTS.fifo_full);
  assign evt_b = (routing_r[ROUTE_READY_B_BIT] && EVENTS.data_ready)
              || (routing_r[ROUTE_LEVEL_B_BIT] && wm_evt)
              || (routing_r[ROUTE_FULL_B_BIT] && EVENTS.fifo_full);

  // Pin drivers: push-pull drives both levels, open-drain only pulls low
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      IRQ_PIN_A_O  <= 1'b0;
      IRQ_PIN_A_OE <= 1'b0;
      IRQ_PIN_B_O  <= 1'b0;
      IRQ_PIN_B_OE <= 1'b0;
    end
    else
    begin
      IRQ_PIN_A_O  <= pin_a_r.drive_od ? 1'b0 : (evt_a == pin_a_r.pol_high);
      IRQ_PIN_A_OE <= pin_a_r.out_en && (!pin_a_r.drive_od || (evt_a != pin_a_r.pol_high));
      IRQ_PIN_B_O  <= pin_b_r.drive_od ? 1'b0 : (evt_b == pin_b_r.pol_high);
      IRQ_PIN_B_OE <= pin_b_r.out_en && (!pin_b_r.drive_od || (evt_b != pin_b_r.pol_high));
    end
  end

  // Pin input synchronisers
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sync_a_r <= 2'b00;
      sync_b_r <= 2'b00;
    end
    else
    begin
      sync_a_r <= {sync_a_r[0], IRQ_PIN_A_I};
      sync_b_r <= {sync_b_r[0], IRQ_PIN_B_I};
    end
  end

  // Input-mode pin levels, active state folded by polarity
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      PIN_A_SEEN <= 1'b0;
      PIN_B_SEEN <= 1'b0;
    end
    else
    begin
      PIN_A_SEEN <= pin_a_r.in_en && (sync_a_r[1] == pin_a_r.pol_high);
      PIN_B_SEEN <= pin_b_r.in_en && (sync_b_r[1] == pin_b_r.pol_high);
    end
  end

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence key_taken_q;
    key_wr && !srst_busy_r;
  endsequence

  sequence delay_runs_q;
    srst_busy_r [*8];
  endsequence

  pin_a_pp_a: assert property (pin_a_r.out_en && !pin_a_r.drive_od && !wr_a && !srst_done
    |=> IRQ_PIN_A_OE && IRQ_PIN_A_O == ($past(evt_a) == pin_a_r.pol_high))
    else $error("pin A push-pull level wrong");
  pin_b_od_a: assert property (pin_b_r.out_en && pin_b_r.drive_od && !wr_b && !srst_done
    |=> !IRQ_PIN_B_O && IRQ_PIN_B_OE == ($past(evt_b) != pin_b_r.pol_high))
    else $error("pin B open-drain drive wrong");
  route_ready_b_a: assert property (routing_r[ROUTE_READY_B_BIT] && EVENTS.data_ready |-> evt_b)
    else $error("data ready not routed to pin B");
  wm_route_b_a: assert property (routing_r[ROUTE_LEVEL_B_BIT] && FIFO_LEVEL >= {1'b0, WTM_LEVEL} |-> evt_b)
    else $error("watermark not routed to pin B");
  full_route_a_a: assert property (routing_r[ROUTE_FULL_A_BIT] && EVENTS.fifo_full |-> evt_a)
    else $error("FIFO full not routed to pin A");
  route_ready_a_a: assert property (routing_r[2] && EVENTS.data_ready |-> evt_a)
    else $error("data ready not routed to pin A");
  wm_route_a_a: assert property (routing_r[1] && FIFO_LEVEL >= {1'b0, WTM_LEVEL} |-> evt_a)
    else $error("watermark not routed to pin A");
  full_route_b_a: assert property (routing_r[4] && EVENTS.fifo_full |-> evt_b)
    else $error("FIFO full not routed to pin B");
  stim_hold_a: assert property (STIMULUS == STIM_POS && !wr_stim && !srst_done |=> STIMULUS == STIM_POS)
    else $error("positive stimulus dropped without write");
  suspend_stop_a: assert property (power_save_r != ACTIVE_VAL |-> !ACQUIRE_EN)
    else $error("acquiring while suspended");
  key_start_a: assert property (key_taken_q |=> delay_runs_q)
    else $error("soft reset did not start");
  srst_restore_a: assert property ($fell(srst_busy_r) |-> power_save_r == POWER_SAVE_RST
    && sensor_on_r == SENSOR_ON_RST && stimulus_r == STIMULUS_RST && routing_r == 7'h00)
    else $error("configuration not restored after soft reset");
  srst_span_a: assert property (srst_done |-> srst_cnt_r == 16'(SRST_CYCLES - 1) && $past(srst_busy_r))
    else $error("soft reset delay length wrong");
  reserved_rd_a: assert property (REG_REQ.rd && REG_REQ.addr == OFS_PIN_A_CFG
    |=> REG_RDATA[7:5] == 3'b000 && !REG_RDATA[0])
    else $error("reserved pin config bits read nonzero");

endmodule

// ---- common/accel_regs_pkg.sv ----
// Register map, field layout, reset values and timing for the accelerometer control registers
package accel_regs_pkg;

  // Register offsets on the serial register port
  localparam logic [6:0] OFS_PIN_A_CFG   = 7'h53;
  localparam logic [6:0] OFS_PIN_B_CFG   = 7'h54;
  localparam logic [6:0] OFS_ROUTING     = 7'h58;
  localparam logic [6:0] OFS_STIMULUS    = 7'h6D;
  localparam logic [6:0] OFS_POWER_SAVE  = 7'h7C;
  localparam logic [6:0] OFS_SENSOR_ON   = 7'h7D;
  localparam logic [6:0] OFS_SOFT_RESET  = 7'h7E;

  // Pin configuration field positions (same for both pins)
  localparam int PIN_IN_EN_BIT  = 4;
  localparam int PIN_OUT_EN_BIT = 3;
  localparam int PIN_DRIVE_BIT  = 2;
  localparam int PIN_POL_BIT    = 1;

  // Routing field positions
  localparam int ROUTE_READY_B_BIT = 6;
  localparam int ROUTE_LEVEL_B_BIT = 5;
  localparam int ROUTE_FULL_B_BIT  = 4;
  localparam int ROUTE_READY_A_BIT = 2;
  localparam int ROUTE_LEVEL_A_BIT = 1;
  localparam int ROUTE_FULL_A_BIT  = 0;

  // Reset values
  localparam logic [7:0] PIN_CFG_RST    = 8'h00;
  localparam logic [7:0] ROUTING_RST    = 8'h00;
  localparam logic [7:0] STIMULUS_RST   = 8'h00;
  localparam logic [7:0] POWER_SAVE_RST = 8'h03;
  localparam logic [7:0] SENSOR_ON_RST  = 8'h00;

  // Encoded register values
  localparam logic [7:0] STIM_OFF_VAL  = 8'h00;
  localparam logic [7:0] STIM_POS_VAL  = 8'h0D;
  localparam logic [7:0] STIM_NEG_VAL  = 8'h09;
  localparam logic [7:0] SUSPEND_VAL   = 8'h03;
  localparam logic [7:0] ACTIVE_VAL    = 8'h00;
  localparam logic [7:0] SENSOR_ON_VAL = 8'h04;
  localparam logic [7:0] RESET_KEY     = 8'hB6;

  // Soft reset delay, watermark and fill level widths
  localparam int CLK_PERIOD_NS     = 100;
  localparam int SRST_DELAY_NS     = 1000000;
  localparam int SRST_DELAY_CYCLES = (SRST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WTM_W             = 13;
  localparam int LEVEL_W           = 14;

  // Stimulus selection as seen by the sensing path
  typedef enum logic [1:0] {STIM_OFF, STIM_POS, STIM_NEG} stim_e;

  // One pin's configuration fields
  typedef struct packed {
    logic in_en;
    logic out_en;
    logic drive_od;
    logic pol_high;
  } pin_cfg_s;

  // Events from the data path
  typedef struct packed {
    logic data_ready;
    logic fifo_full;
  } events_s;

  // Register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

endpackage

// ---- dv/reg_host_model.sv ----
// Host processor model issuing single-byte register strobes
`timescale 1ns/1ps
module reg_host_model (
  // Clock
  input  wire logic               CLK,
  // Register port
  output accel_regs_pkg::reg_req_s REQ,
  input  wire logic [7:0]         RDATA
);
  import accel_regs_pkg::*;
  initial REQ = '0;
  // Write strobe held to its sampling edge; idle fields show inverted values
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge CLK);
    REQ <= '{1'b1, 1'b0, a, d};
    @(posedge CLK);
    REQ <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  // Read strobe; data is taken once the answering edge has landed
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge CLK);
    REQ <= '{1'b0, 1'b1, a, 8'hFF};
    @(posedge CLK);
    REQ <= '{1'b0, 1'b0, ~a, 8'h00};
    #1 d = RDATA;
  endtask
  // Only the key is ever sent to the reset command register
  task automatic srst();
    wr(OFS_SOFT_RESET, RESET_KEY);
  endtask
endmodule

// ---- dv/tb_accel_pin_power_reset_regs.sv ----
// Self-checking testbench for the accelerometer control registers
`timescale 1ns/1ps
module tb_accel_pin_power_reset_regs;
  import accel_regs_pkg::*;
  localparam int SRST = 20;
  logic                clk;
  logic                rst_n;
  reg_req_s            host_req;
  logic [7:0]          rdata;
  events_s             evts;
  logic [LEVEL_W-1:0]  fifo_lvl;
  logic [WTM_W-1:0]    wtm_lvl;
  logic                ext_a, ext_b, pa_o, pa_oe, pb_o, pb_oe, seen_a, seen_b, acq, busy;
  stim_e               stim;
  int                  bad_count = 0;
  int                  n_checks = 0;
  // Pin levels seen by the design: own drive wins, else the outside
  wire pin_a = pa_oe ? pa_o : ext_a;
  wire pin_b = pb_oe ? pb_o : ext_b;
  reg_host_model u_host (.CLK(clk), .REQ(host_req), .RDATA(rdata));
  accel_pin_power_reset_regs #(.SRST_CYCLES(SRST)) u_dut (
    .CLK(clk), .RST_N(rst_n), .REG_REQ(host_req), .REG_RDATA(rdata),
    .EVENTS(evts), .FIFO_LEVEL(fifo_lvl), .WTM_LEVEL(wtm_lvl),
    .IRQ_PIN_A_I(pin_a), .IRQ_PIN_A_O(pa_o), .IRQ_PIN_A_OE(pa_oe), .PIN_A_SEEN(seen_a),
    .IRQ_PIN_B_I(pin_b), .IRQ_PIN_B_O(pb_o), .IRQ_PIN_B_OE(pb_oe), .PIN_B_SEEN(seen_b),
    .STIMULUS(stim), .ACQUIRE_EN(acq), .SOFT_RESET_BUSY(busy));
  always #50 clk = ~clk;
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Compare helpers
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string m);
    chk8({7'h00, got}, {7'h00, exp}, m);
  endtask
  task automatic chk_stim(input stim_e got, input stim_e exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t stimulus %0d exp %0d", $time, got, exp);
    end
  endtask
  // Lets registered outputs and the input synchroniser settle
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask
  // Every register at its reset value, reserved place and command register read zero
  task automatic t_reset_vals();
    logic [6:0] ofs[8] = '{OFS_PIN_A_CFG, OFS_PIN_B_CFG, OFS_ROUTING, OFS_STIMULUS,
                           OFS_POWER_SAVE, OFS_SENSOR_ON, OFS_SOFT_RESET, 7'h10};
    logic [7:0] got;
    for (int i = 0; i < 8; i++)
    begin
      u_host.rd(ofs[i], got);
      chk8(got, (ofs[i] == OFS_POWER_SAVE) ? POWER_SAVE_RST : 8'h00, "reset value");
    end
    chk1(acq, 1'b0, "acquire after reset");
    chk_stim(stim, STIM_OFF);
  endtask
  // Reserved bits are dropped, unmapped writes ignored
  task automatic t_reserved();
    logic [6:0] ofs[4] = '{OFS_PIN_A_CFG, OFS_PIN_B_CFG, OFS_ROUTING, 7'h10};
    logic [7:0] exp[4] = '{8'h1E, 8'h1E, 8'h77, 8'h00};
    logic [7:0] got;
    for (int i = 0; i < 4; i++)
    begin
      u_host.wr(ofs[i], 8'hFF);
      u_host.rd(ofs[i], got);
      chk8(got, exp[i], "masked readback");
    end
  endtask
  // Drives one event: 0 ready, 1 watermark at its exact threshold, 2 full
  task automatic set_evt(input int k, input logic on);
    if (k == 0)
      evts.data_ready <= on;
    else if (k == 2)
      evts.fifo_full <= on;
    else
      fifo_lvl <= on ? 14'h1000 : 14'h0FFF;
  endtask
  // Each routing bit carries its own event to its own pin only
  task automatic t_routing();
    int pos[6] = '{6, 5, 4, 2, 1, 0};
    u_host.wr(OFS_PIN_A_CFG, 8'h0A);
    u_host.wr(OFS_PIN_B_CFG, 8'h0A);
    for (int i = 0; i < 6; i++)
    begin
      u_host.wr(OFS_ROUTING, 8'h01 << pos[i]);
      set_evt(i % 3, 1'b1);
      settle();
      chk1(i < 3 ? pb_o : pa_o, 1'b1, "routed event");
      chk1(i < 3 ? pa_o : pb_o, 1'b0, "other pin");
      chk1(i < 3 ? pb_oe : pa_oe, 1'b1, "push-pull enabled");
      set_evt(i % 3, 1'b0);
      settle();
      chk1(i < 3 ? pb_o : pa_o, 1'b0, "event gone");
    end
  endtask
  // Polarity, open-drain, output off and input mode
  task automatic t_pin_modes();
    u_host.wr(OFS_ROUTING, 8'h01);
    u_host.wr(OFS_PIN_A_CFG, 8'h08);
    set_evt(2, 1'b1);
    settle();
    chk1(pa_o, 1'b0, "active low");
    chk1(pa_oe, 1'b1, "push-pull drives");
    u_host.wr(OFS_PIN_A_CFG, 8'h0E);
    settle();
    chk1(pa_oe, 1'b0, "open-drain released");
    set_evt(2, 1'b0);
    settle();
    chk1(pa_oe, 1'b1, "open-drain pulls");
    chk1(pa_o, 1'b0, "open-drain low");
    u_host.wr(OFS_PIN_A_CFG, 8'h12);
    ext_a <= 1'b1;
    settle();
    chk1(pa_oe, 1'b0, "output off");
    chk1(seen_a, 1'b1, "input high seen");
    u_host.wr(OFS_PIN_B_CFG, 8'h10);
    ext_b <= 1'b0;
    settle();
    chk1(seen_b, 1'b1, "input low seen");
    chk1(pb_oe, 1'b0, "pin B output off");
  endtask
  // Stimulus codes; the host itself switches it off at the end
  task automatic t_stimulus();
    u_host.wr(OFS_STIMULUS, STIM_POS_VAL);
    repeat (50) @(posedge clk);
    #1 chk_stim(stim, STIM_POS);
    u_host.wr(OFS_STIMULUS, STIM_NEG_VAL);
    #1 chk_stim(stim, STIM_NEG);
    u_host.wr(OFS_STIMULUS, STIM_OFF_VAL);
    #1 chk_stim(stim, STIM_OFF);
  endtask
  // Acquisition needs sensor on and active power setting
  task automatic t_power();
    u_host.wr(OFS_SENSOR_ON, SENSOR_ON_VAL);
    #1 chk1(acq, 1'b0, "suspend blocks");
    u_host.wr(OFS_POWER_SAVE, ACTIVE_VAL);
    #1 chk1(acq, 1'b1, "active acquires");
    u_host.wr(OFS_POWER_SAVE, SUSPEND_VAL);
    #1 chk1(acq, 1'b0, "suspend again");
  endtask
  // Key written while suspended; restore after exactly SRST cycles
  task automatic t_soft_reset();
    int n = 0;
    u_host.wr(OFS_STIMULUS, STIM_POS_VAL);
    u_host.srst();
    #1 chk1(busy, 1'b1, "reset started");
    while (busy === 1'b1 && n < 40)
    begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 40)
    begin
      bad_count++;
      tally_and_finish();
    end
    else
    begin
      chk8(n[7:0], 8'(SRST), "restore delay");
      t_reset_vals();
    end
  endtask
  // Main sequence
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    evts = '0;
    fifo_lvl = '0;
    wtm_lvl = 13'h1000;
    ext_a = 1'b0;
    ext_b = 1'b1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_vals();
    t_reserved();
    t_routing();
    t_pin_modes();
    t_stimulus();
    t_power();
    t_soft_reset();
    tally_and_finish();
  end
endmodule
